// [ebm_cfg.svh]
// constants for the embedded block memory: offsets, fields, sizes
`ifndef EBM_CFG_SVH
`define EBM_CFG_SVH
`define EBM_ARRAY_BITS 18432
`define EBM_LANE_BITS  9
`define EBM_REG_CTRL   4'h0
`define EBM_REG_STAT   4'h4
`define EBM_CTRL_RST   8'h00
`define EBM_F_WMODE    0
`define EBM_F_OREG     2
`define EBM_F_ASYNC    3
`define EBM_F_NIB      4
`endif

// [ebm_pkg.sv]
// types shared by the embedded block memory
package ebm_pkg;
  typedef enum logic [1:0] {
    EBM_WM_NORMAL = 2'h0,
    EBM_WM_THRU   = 2'h1,
    EBM_WM_RBW    = 2'h2
  } ebm_wmode_t;
  // one-hot memory arrangement
  typedef enum logic [2:0] {
    EBM_SP  = 3'h1,
    EBM_TDP = 3'h2,
    EBM_PDP = 3'h4
  } ebm_mode_t;
  typedef struct packed {
    logic [7:0]        ctrl;
    logic [31:0]       rdata;
    logic [1:0]        ce;
    logic [1:0]        we;
    logic [1:0][13:0]  addr;
    logic [1:0][35:0]  din;
    logic [1:0][3:0]   be;
  } ebm_state_t;
endpackage : ebm_pkg

// [ebm_block_ram.sv]
// embedded block memory: two ports, one shared array, config port
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`include "ebm_cfg.svh"

module ebm_block_ram
  import ebm_pkg::*;
#(
  parameter int        WIDTH_A = 18,
  parameter int        WIDTH_B = 18,
  parameter ebm_mode_t MODE    = EBM_TDP,
  parameter logic [`EBM_ARRAY_BITS-1:0] INIT = '0
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        global_set_reset_n_i,
  input  wire logic [3:0]  cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  input  wire logic        cfg_we_i,
  input  wire logic        cfg_re_i,
  output logic      [31:0] cfg_rdata_o,
  input  wire logic        port_a_clk_en_i,
  input  wire logic        port_a_we_i,
  input  wire logic [13:0] port_a_addr_i,
  input  wire logic [35:0] port_a_wdata_i,
  input  wire logic [3:0]  port_a_be_i,
  input  wire logic        port_a_output_reset_i,
  output logic      [35:0] port_a_rdata_o,
  input  wire logic        port_b_clk_en_i,
  input  wire logic        port_b_we_i,
  input  wire logic [13:0] port_b_addr_i,
  input  wire logic [35:0] port_b_wdata_i,
  input  wire logic [3:0]  port_b_be_i,
  input  wire logic        port_b_output_reset_i,
  output logic      [35:0] port_b_rdata_o
);

  // =====================================================
  // port bundling
  ebm_state_t            st_r;
  ebm_state_t            st_nxt;
  logic [`EBM_ARRAY_BITS-1:0] mem_r = INIT;
  logic [1:0]            ce_in;
  logic [1:0]            we_in;
  logic [1:0]            rst_in;
  logic [1:0][13:0]      addr_in;
  logic [1:0][35:0]      din_in;
  logic [1:0][3:0]       be_in;
  logic [1:0][35:0]      word_all;
  logic [1:0][35:0]      wmask_all;
  logic [1:0][35:0]      dout_all;
  logic [1:0][19:0]      base_all;
  logic [1:0]            wr_ok;
  logic [1:0]            used;

  assign ce_in   = {port_b_clk_en_i, port_a_clk_en_i};
  assign we_in   = {port_b_we_i, port_a_we_i};
  assign rst_in  = {port_b_output_reset_i, port_a_output_reset_i};
  assign addr_in = {port_b_addr_i, port_a_addr_i};
  assign din_in  = {port_b_wdata_i, port_a_wdata_i};
  assign be_in   = {port_b_be_i, port_a_be_i};
  // single port leaves b idle; pseudo dual writes on a, reads on b
  assign used    = {MODE != EBM_SP, 1'b1};
  assign wr_ok   = {MODE == EBM_TDP, 1'b1};
  assign port_a_rdata_o = dout_all[0];
  assign port_b_rdata_o = dout_all[1];
  assign cfg_rdata_o    = st_r.rdata;

  // =====================================================
  // input stage and config port
  always_comb begin
    st_nxt = st_r;
    for (int p = 0; p < 2; p++) begin
      st_nxt.ce[p] = ce_in[p] & used[p];
      if (ce_in[p]) begin
        st_nxt.addr[p] = addr_in[p];
        st_nxt.din[p]  = din_in[p];
        st_nxt.we[p]   = we_in[p] & wr_ok[p];
        st_nxt.be[p]   = be_in[p];
      end
    end
    if (cfg_we_i && cfg_addr_i == `EBM_REG_CTRL) begin
      st_nxt.ctrl = cfg_wdata_i[7:0];
    end
    // read data stands one cycle only
    st_nxt.rdata = 32'h0000_0000;
    if (cfg_re_i) begin
      case (cfg_addr_i)
        `EBM_REG_CTRL: st_nxt.rdata = {24'h00_0000, st_r.ctrl};
        `EBM_REG_STAT: st_nxt.rdata = {25'h000_0000, MODE,
                                       st_r.we, st_r.ce};
        default:       st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r      <= '0;
      st_r.ctrl <= `EBM_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =====================================================
  // per-port array access and output stages
  genvar gp;
  for (gp = 0; gp < 2; gp++) begin : g_port
    localparam int W     = (gp == 0) ? WIDTH_A : WIDTH_B;
    localparam bit RBW   = (W % `EBM_LANE_BITS) == 0;
    localparam bit LANES = (W == 18) || (W == 36);
    localparam bit RD_OK = !((MODE == EBM_PDP) && (gp == 0));
    localparam int NIB   = gp * `EBM_F_NIB;
    logic [35:0] latch_r;
    logic [35:0] latch_nxt;
    logic [35:0] dout_r;
    logic [35:0] dout_nxt;
    logic [1:0]  wmode;
    logic        oreg;
    logic        async_clr;
    logic        arst;
    logic        srst;

    assign wmode     = st_r.ctrl[NIB+`EBM_F_WMODE +: 2];
    assign oreg      = st_r.ctrl[NIB+`EBM_F_OREG];
    assign async_clr = st_r.ctrl[NIB+`EBM_F_ASYNC];
    // each port scales its own address by its own width; twenty
    // bits hold the top address times 36, so no word wraps into range
    assign base_all[gp] = 20'(st_r.addr[gp] * W);
    // local clear hits only this port; global clears both
    assign arst = rst_i | ~global_set_reset_n_i
                | (rst_in[gp] & async_clr);
    assign srst = rst_in[gp] & ~async_clr;

    // word fetch and write mask, bit i of word at base + i
    always_comb begin
      word_all[gp]  = '0;
      wmask_all[gp] = '0;
      for (int i = 0; i < 36; i++) begin
        if (i < W && int'(base_all[gp]) + i < `EBM_ARRAY_BITS) begin
          word_all[gp][i]  = mem_r[int'(base_all[gp]) + i];
          wmask_all[gp][i] = LANES ?
            st_r.be[gp][i / `EBM_LANE_BITS] : 1'b1;
        end
      end
    end

    // latch follows the write mode; dout is the output register
    always_comb begin
      latch_nxt = latch_r;
      if (srst) begin
        latch_nxt = '0;
      end else if (st_r.ce[gp] && RD_OK) begin
        if (!st_r.we[gp]) begin
          latch_nxt = word_all[gp];
        end else begin
          case (wmode)
            EBM_WM_THRU: latch_nxt = st_r.din[gp] & wmask_all[gp];
            EBM_WM_RBW:  latch_nxt = RBW ? word_all[gp] : latch_r;
            default:     latch_nxt = latch_r;
          endcase
        end
      end
      // bypass loads the latch value itself, one stage earlier
      if (srst) begin
        dout_nxt = '0;
      end else if (!oreg) begin
        dout_nxt = latch_nxt;
      end else if (ce_in[gp]) begin
        dout_nxt = latch_r;
      end else begin
        dout_nxt = dout_r;
      end
    end

    always_ff @(posedge sys_clk_i or posedge arst) begin
      if (arst) begin
        latch_r <= '0;
        dout_r  <= '0;
      end else begin
        latch_r <= latch_nxt;
        dout_r  <= dout_nxt;
      end
    end
    assign dout_all[gp] = dout_r;
  end

  // =====================================================
  // array write: b is applied after a, so b's bits win a collision;
  // the latch reads the old word at this same edge
  always_ff @(posedge sys_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (st_r.ce[p] && st_r.we[p]) begin
        for (int i = 0; i < 36; i++) begin
          if (wmask_all[p][i]) begin
            mem_r[int'(base_all[p]) + i] <= st_r.din[p][i];
          end
        end
      end
    end
  end

  // =====================================================
  // checks on both ports and on the configuration
  logic        rd_a;
  logic        wr_a;
  logic        quiet_a;
  logic [1:0]  wm_a;
  logic        oreg_a;
  logic        rd_b;
  logic        quiet_b;
  logic        oreg_b;
  assign wm_a    = st_r.ctrl[`EBM_F_WMODE +: 2];
  assign oreg_a  = st_r.ctrl[`EBM_F_OREG];
  assign quiet_a = global_set_reset_n_i & ~port_a_output_reset_i;
  assign rd_a    = st_r.ce[0] & ~st_r.we[0] & quiet_a;
  assign wr_a    = st_r.ce[0] & st_r.we[0] & quiet_a;
  assign oreg_b  = st_r.ctrl[`EBM_F_NIB+`EBM_F_OREG];
  assign quiet_b = global_set_reset_n_i & ~port_b_output_reset_i;
  assign rd_b    = st_r.ce[1] & ~st_r.we[1] & quiet_b;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_cfg_legal: assert property (
    !(MODE == EBM_TDP && (WIDTH_A > 18 || WIDTH_B > 18)))
    else $error("dual port width above 18");
  a_input_capture: assert property (
    port_a_clk_en_i |=> st_r.addr[0] == $past(port_a_addr_i)
      && st_r.din[0] == $past(port_a_wdata_i))
    else $error("port a inputs not registered");
  a_bypass_read: assert property (
    rd_a && !oreg_a && MODE != EBM_PDP
      |=> port_a_rdata_o == $past(word_all[0]))
    else $error("bypassed read not one stage");
  a_normal_hold: assert property (
    wr_a && !oreg_a && wm_a == EBM_WM_NORMAL |=> $stable(port_a_rdata_o))
    else $error("normal write changed output");
  a_write_thru: assert property (
    wr_a && !oreg_a && wm_a == EBM_WM_THRU
      |=> port_a_rdata_o == $past(st_r.din[0] & wmask_all[0]))
    else $error("write-through data missing");
  a_rbw_old: assert property (
    wr_a && !oreg_a && wm_a == EBM_WM_RBW && (WIDTH_A % 9) == 0
      |=> port_a_rdata_o == $past(word_all[0]))
    else $error("old data not shown");
  a_sync_clear: assert property (
    port_a_output_reset_i && !st_r.ctrl[`EBM_F_ASYNC]
      |=> port_a_rdata_o == '0)
    else $error("sync clear failed");
  a_local_only: assert property (
    port_a_output_reset_i && !port_b_output_reset_i
      && global_set_reset_n_i && !st_r.ce[1] && !port_b_clk_en_i
      |=> $stable(port_b_rdata_o))
    else $error("port a reset touched port b");
  a_global_clear: assert property (
    !global_set_reset_n_i |-> port_a_rdata_o == '0
      && port_b_rdata_o == '0)
    else $error("global reset left data");
  a_oreg_hold: assert property (
    oreg_a && !port_a_clk_en_i && quiet_a |=> $stable(port_a_rdata_o))
    else $error("output register moved without enable");
  // port b shares the read path and the clear, each on its own nibble
  a_b_bypass: assert property (
    rd_b && !oreg_b |=> port_b_rdata_o == $past(word_all[1]))
    else $error("port b bypassed read wrong");
  a_b_sync_clear: assert property (
    port_b_output_reset_i && !st_r.ctrl[`EBM_F_NIB+`EBM_F_ASYNC]
      |=> port_b_rdata_o == '0)
    else $error("port b sync clear failed");
  a_stat_mode: assert property (
    cfg_re_i && cfg_addr_i == `EBM_REG_STAT |=> cfg_rdata_o[6:4] == MODE)
    else $error("status shows wrong arrangement");

  c_thru: cover property (wr_a && wm_a == EBM_WM_THRU);
  c_rbw:  cover property (wr_a && wm_a == EBM_WM_RBW);
  c_oreg: cover property (rd_a && oreg_a ##[1:3] port_a_clk_en_i);
  c_gsr:  cover property (!global_set_reset_n_i);
  c_bclr: cover property (port_b_output_reset_i);

endmodule : ebm_block_ram

// [ebm_user_port.sv]
// fabric-side user logic model that drives one memory port
`timescale 1ns/1ps
module ebm_user_port (
  input  wire logic        clk_i,
  output logic             clk_en_o,
  output logic             we_o,
  output logic      [13:0] addr_o,
  output logic      [35:0] wdata_o,
  output logic      [3:0]  be_o
);
  // =========================================
  // idle: writes held off so a preload stays intact
  initial begin
    clk_en_o = 1'b0;
    we_o     = 1'b0;
    addr_o   = 14'h0000;
    wdata_o  = 36'h0_0000_0000;
    be_o     = 4'h0;
  end

  // one request held for one edge, then released with scrambled lines
  // so stale values never pass for valid ones; each instance drives its own port
  task automatic op(input logic w, input logic [13:0] a,
                    input logic [35:0] d, input logic [3:0] b);
    @(posedge clk_i);
    clk_en_o <= 1'b1;
    we_o     <= w;
    // the caller owns the addressing, as fifo pointers would be
    addr_o   <= a;
    wdata_o  <= d;
    be_o     <= b;
    @(posedge clk_i);
    clk_en_o <= 1'b0;
    we_o     <= 1'b0;
    addr_o   <= ~a;
    wdata_o  <= ~d;
    @(posedge clk_i);
    #1;
  endtask : op
endmodule : ebm_user_port

// [tb_ebm_block_ram.sv]
// testbench for the embedded block memory
`timescale 1ns/1ps
module tb_ebm_block_ram;
  import ebm_pkg::*;
  localparam logic [35:0] ROM_A0 = 36'h0_0001_6789;
  logic        clk, rst, gsr_n, cfg_we, cfg_re, a_rst, b_rst;
  logic [3:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  wire         a_en, a_we, b_en, b_we;
  wire  [13:0] a_addr, b_addr;
  wire  [35:0] a_wd, b_wd;
  wire  [3:0]  a_be, b_be;
  logic [35:0] a_rd, b_rd, cur, v, exp;
  int          errors, compares;

  ebm_user_port u_ebm_user_port_a (.clk_i(clk), .clk_en_o(a_en),
    .we_o(a_we), .addr_o(a_addr), .wdata_o(a_wd), .be_o(a_be));
  ebm_user_port u_ebm_user_port_b (.clk_i(clk), .clk_en_o(b_en),
    .we_o(b_we), .addr_o(b_addr), .wdata_o(b_wd), .be_o(b_be));

  ebm_block_ram #(.WIDTH_A(18), .WIDTH_B(9), .MODE(EBM_TDP),
    .INIT(18432'h0001_2345_6789)) u_ebm_block_ram (
    .sys_clk_i(clk), .rst_i(rst), .global_set_reset_n_i(gsr_n),
    .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata), .cfg_we_i(cfg_we),
    .cfg_re_i(cfg_re), .cfg_rdata_o(cfg_rdata),
    .port_a_clk_en_i(a_en), .port_a_we_i(a_we), .port_a_addr_i(a_addr),
    .port_a_wdata_i(a_wd), .port_a_be_i(a_be),
    .port_a_output_reset_i(a_rst), .port_a_rdata_o(a_rd),
    .port_b_clk_en_i(b_en), .port_b_we_i(b_we), .port_b_addr_i(b_addr),
    .port_b_wdata_i(b_wd), .port_b_be_i(b_be),
    .port_b_output_reset_i(b_rst), .port_b_rdata_o(b_rd));

  // =========================================
  // clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [35:0] got, input logic [35:0] want);
    compares++;
    if (got !== want) begin
      errors++;
      $display("BAD at %0t: got %h want %h", $time, got, want);
    end
  endtask : check

  // config bus: one-cycle strobes, read data in the following cycle
  task automatic cfg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_addr  <= a;
    cfg_wdata <= {24'h00_0000, d};
    cfg_we    <= 1'b1;
    @(posedge clk);
    cfg_we    <= 1'b0;
  endtask : cfg_wr

  task automatic cfg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_re   <= 1'b1;
    @(posedge clk);
    cfg_re   <= 1'b0;
    #1;
    d = cfg_rdata;
  endtask : cfg_rd

  // local clear of port a for one edge
  task automatic clear_a;
    @(posedge clk);
    a_rst <= 1'b1;
    @(posedge clk);
    a_rst <= 1'b0;
    #1;
  endtask : clear_a

  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // watchdog: the tests need well under a thousand cycles
  initial begin
    #50000;
    errors++;
    give_verdict();
  end

  // =========================================
  // test sequence
  initial begin
    {rst, gsr_n, cfg_we, cfg_re, a_rst, b_rst} = 6'b110000;
    cfg_addr  = 4'h0;
    cfg_wdata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cfg_rd(4'h0, rd);
    check(36'(rd), 36'h0_0000_0000);
    cfg_rd(4'h4, rd);
    check(36'(rd & 32'h0000_0070), 36'h0_0000_0020);
    cfg_rd(4'hC, rd);
    check(36'(rd), 36'h0_0000_0000);
    $display("test 1 done");
    u_ebm_user_port_a.op(1'b0, 14'h0000, '0, 4'hF);
    check(a_rd, ROM_A0);
    u_ebm_user_port_b.op(1'b0, 14'h0001, '0, 4'hF);
    check(b_rd, 36'h0_0000_00B3);
    $display("test 2 done");
    // every write mode: the preceding read shows what normal keeps
    cur = '0;
    for (int m = 0; m < 3; m++) begin
      cfg_wr(4'h0, 8'(m));
      u_ebm_user_port_a.op(1'b0, 14'h0000, '0, 4'hF);
      v = 36'(18'h2_A5C3 ^ 18'(m));
      u_ebm_user_port_a.op(1'b1, 14'h0003, v, 4'hF);
      exp = (m == 1) ? v : (m == 2) ? cur : ROM_A0;
      check(a_rd, exp);
      cur = v;
    end
    $display("test 3 done");
    cfg_wr(4'h0, 8'h00);
    u_ebm_user_port_a.op(1'b1, 14'h0003, 36'h0_0003_FFFF, 4'h1);
    u_ebm_user_port_a.op(1'b0, 14'h0003, '0, 4'hF);
    check(a_rd, {18'h0_0000, cur[17:9], 9'h1FF});
    u_ebm_user_port_b.op(1'b0, 14'h0006, '0, 4'hF);
    check(b_rd, 36'h0_0000_01FF);
    $display("test 4 done");
    clear_a();
    check(a_rd, 36'h0_0000_0000);
    check(b_rd, 36'h0_0000_01FF);
    u_ebm_user_port_a.op(1'b0, 14'h0000, '0, 4'hF);
    // the read landed inside op; one spare edge passes before the global clear
    @(posedge clk);
    gsr_n <= 1'b0;
    #1;
    check(a_rd, 36'h0_0000_0000);
    check(b_rd, 36'h0_0000_0000);
    @(posedge clk);
    gsr_n <= 1'b1;
    fork
      u_ebm_user_port_a.op(1'b0, 14'h0000, '0, 4'hF);
      u_ebm_user_port_b.op(1'b0, 14'h0006, '0, 4'hF);
    join
    @(posedge clk);
    b_rst <= 1'b1;
    @(posedge clk);
    b_rst <= 1'b0;
    #1;
    check(b_rd, 36'h0_0000_0000);
    check(a_rd, ROM_A0);
    $display("test 5 done");
    // output register: one stage later and frozen while disabled
    cfg_wr(4'h0, 8'h04);
    clear_a();
    u_ebm_user_port_a.op(1'b0, 14'h0000, '0, 4'hF);
    check(a_rd, 36'h0_0000_0000);
    u_ebm_user_port_a.op(1'b0, 14'h0000, '0, 4'hF);
    check(a_rd, ROM_A0);
    $display("test 6 done");
    cfg_wr(4'h0, 8'h08);
    clear_a();
    u_ebm_user_port_a.op(1'b0, 14'h0000, '0, 4'hF);
    check(a_rd, ROM_A0);
    // async clear shows before the next edge could sample it
    @(posedge clk);
    a_rst <= 1'b1;
    #1;
    check(a_rd, 36'h0_0000_0000);
    @(posedge clk);
    a_rst <= 1'b0;
    $display("test 7 done");
    give_verdict();
  end
endmodule : tb_ebm_block_ram
